// >>> abt_cfg.svh
// constants of the address bus tenure block: widths, masks, timing counts
// assumes the bus clock is the block clock CLK; no other header needed
//
// Operation
// - drive busy asserted the cycle after an accepted qualified grant, hold while master
// - aborted pending request leaves busy negated after a qualified grant
// - after address acknowledge, drive busy negated at least half a cycle
// - after driving busy negated, release busy to high impedance
// - busy seen asserted by another party blocks taking the bus
// - busy seen negated means the bus is free given a qualified grant
// - transfer start marks valid address; implies data request unless address-only
// - transfer start asserts in the same cycle busy first asserts
// - transfer start negates one cycle after assertion
// - transfer start releases together with busy negation
// - transfer start from another master makes address and type valid for snooping
// - bidirectional 32-bit physical address bus
// - burst read gives critical double word; burst write gives line's first double word
// - address held constant through a burst, never incremented
// - address driven the cycle after qualified grant, with busy and start
// - address released one cycle after address acknowledge
// - qualified grant: grant asserted, busy negated, no retry after acknowledge
// - grant ignored between any transfer start and its acknowledge

`ifndef ABT_CFG_SVH
`define ABT_CFG_SVH

// ==========================================
// widths
`define ABT_ADDR_W       32
`define ABT_TT_W         5

// ==========================================
// transfer type bit positions, bit 4 is the first type line
`define ABT_TT_B0        4
`define ABT_TT_B2        2
`define ABT_TT_B3        1
`define ABT_TT_B4        0

// ==========================================
// burst address masks
`define ABT_DW_MASK      32'hFFFF_FFF8
`define ABT_LINE_MASK    32'hFFFF_FFE0

// ==========================================
// timing
`define ABT_CLK_MHZ      250
`define ABT_NEG_HOLD_PS  2000
`define ABT_NEG_HOLD_CYC ((`ABT_NEG_HOLD_PS * `ABT_CLK_MHZ + 999999) / 1000000)

// ==========================================
// idle pin levels
`define ABT_NEG_LVL      1'b1

`endif

// >>> abt_pkg.sv
// types shared by the address bus tenure modules
// assumes abt_cfg.svh is reachable on the include path

package abt_pkg;
`include "abt_cfg.svh"

   // ==========================================
   // tenure sequencer
   typedef enum logic [1:0] {
      ABT_IDLE,
      ABT_OWN,
      ABT_NEG
   } abt_state_t;

   typedef struct packed {
      abt_state_t                 st;
      logic [1:0]                 hold_cnt;
      logic                       abb_o;
      logic                       abb_oe;
      logic                       ts_o;
      logic                       ts_oe;
      logic [`ABT_ADDR_W-1:0]     a_o;
      logic                       a_oe;
      logic [`ABT_TT_W-1:0]       tt_o;
      logic                       tt_oe;
      logic                       ts_pend;
      logic                       addr_ack_n_d;
      logic                       taken;
      logic                       done;
      logic                       declined;
      logic                       dbus_req;
      logic                       owner;
   } abt_ten_st_t;

   // ==========================================
   // snoop capture
   typedef struct packed {
      logic                       valid;
      logic [`ABT_ADDR_W-1:0]     addr;
      logic [`ABT_TT_W-1:0]       tt;
   } abt_snp_st_t;

endpackage

// >>> abt_addr_sel.sv
// burst address shaping and address-only decode of the transfer type
// assumes inputs are stable while a request waits; purely combinational

`timescale 1ns/1ns

module abt_addr_sel
   import abt_pkg::*;
(
   input  wire logic [`ABT_ADDR_W-1:0] req_addr,
   input  wire logic                   req_burst,
   input  wire logic                   req_write,
   input  wire logic [`ABT_TT_W-1:0]   req_tt,
   output logic      [`ABT_ADDR_W-1:0] bus_addr,
   output logic                        addr_only
);

   // ==========================================
   // address choice
   always_comb
   begin
      bus_addr = req_addr;
      if (req_burst)
      begin
         if (req_write)
            bus_addr = req_addr & `ABT_LINE_MASK;
         else
            bus_addr = req_addr & `ABT_DW_MASK;
      end
   end

   // ==========================================
   // address-only types: second-from-low bit clear, except control word transfers
   always_comb
   begin
      addr_only = !req_tt[`ABT_TT_B3] &&
                  !(req_tt[`ABT_TT_B0] && req_tt[`ABT_TT_B2] && !req_tt[`ABT_TT_B4]);
   end

endmodule

// >>> abt_snoop.sv
// captures address and type when another master starts a transfer
// assumes bus pins are synchronous to clk and own_ts_oe is registered

`timescale 1ns/1ns

module abt_snoop
   import abt_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   srst,
   input  wire logic                   ts_n_i,
   input  wire logic                   own_ts_oe,
   input  wire logic [`ABT_ADDR_W-1:0] addr_i,
   input  wire logic [`ABT_TT_W-1:0]   tt_i,
   output logic                        snp_valid,
   output logic      [`ABT_ADDR_W-1:0] snp_addr,
   output logic      [`ABT_TT_W-1:0]   snp_tt
);

   localparam abt_snp_st_t SNP_RST = '0;

   abt_snp_st_t snp_ff;
   abt_snp_st_t nxt_snp;

   // ==========================================
   // capture
   // one-cycle start strobe from others gives one capture per transfer
   always_comb
   begin
      nxt_snp       = snp_ff;
      nxt_snp.valid = 1'b0;
      if (!ts_n_i && !own_ts_oe)
      begin
         nxt_snp.valid = 1'b1;
         nxt_snp.addr  = addr_i;
         nxt_snp.tt    = tt_i;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         snp_ff <= SNP_RST;
      else
         snp_ff <= nxt_snp;
   end

   assign snp_valid = snp_ff.valid;
   assign snp_addr  = snp_ff.addr;
   assign snp_tt    = snp_ff.tt;

endmodule

// >>> abt_tenure.sv
// address tenure of the system bus master: busy, transfer start, address
// assumes all bus pins switch on CLK edges; the testbench resolves the wires
// from the _O/_OE pairs; request, grant, acknowledge and retry come from
// outside this block

`timescale 1ns/1ns

module abt_tenure
   import abt_pkg::*;
(
   input  wire logic                   CLK,
   input  wire logic                   SRST,

   // user request side
   input  wire logic                   REQ_VALID,
   input  wire logic                   REQ_ABORT,
   input  wire logic [`ABT_ADDR_W-1:0] REQ_ADDR,
   input  wire logic [`ABT_TT_W-1:0]   REQ_TT,
   input  wire logic                   REQ_BURST,
   input  wire logic                   REQ_WRITE,
   output logic                        REQ_TAKEN,
   output logic                        REQ_DONE,
   output logic                        REQ_DECLINED,
   output logic                        DATA_BUS_REQ,
   output logic                        BUS_OWNER,

   // snoop side
   output logic                        SNP_VALID,
   output logic      [`ABT_ADDR_W-1:0] SNP_ADDR,
   output logic      [`ABT_TT_W-1:0]   SNP_TT,

   // arbitration and termination inputs
   input  wire logic                   BUS_GRANT_N,
   input  wire logic                   ADDR_ACK_N,
   input  wire logic                   ADDR_RETRY_N,

   // busy pin
   input  wire logic                   ADDR_BUS_BUSY_N_I,
   output logic                        ADDR_BUS_BUSY_N_O,
   output logic                        ADDR_BUS_BUSY_N_OE,

   // transfer start pin
   input  wire logic                   TRANSFER_START_N_I,
   output logic                        TRANSFER_START_N_O,
   output logic                        TRANSFER_START_N_OE,

   // address bus
   input  wire logic [`ABT_ADDR_W-1:0] ADDR_I,
   output logic      [`ABT_ADDR_W-1:0] ADDR_O,
   output logic                        ADDR_OE,

   // transfer type lines
   input  wire logic [`ABT_TT_W-1:0]   TRANSFER_TYPE_I,
   output logic      [`ABT_TT_W-1:0]   TRANSFER_TYPE_O,
   output logic                        TRANSFER_TYPE_OE
);

   // ==========================================
   // constants
   localparam logic [1:0] NEG_HOLD = 2'(`ABT_NEG_HOLD_CYC);
   localparam logic [1:0] NEG_LAST = NEG_HOLD - 2'd1;

   localparam abt_ten_st_t TEN_RST = '{
      st       : ABT_IDLE,
      hold_cnt : 2'd0,
      abb_o    : `ABT_NEG_LVL,
      abb_oe   : 1'b0,
      ts_o     : `ABT_NEG_LVL,
      ts_oe    : 1'b0,
      a_o      : 32'h0000_0000,
      a_oe     : 1'b0,
      tt_o     : 5'h00,
      tt_oe    : 1'b0,
      ts_pend  : 1'b0,
      addr_ack_n_d   : 1'b0,
      taken    : 1'b0,
      done     : 1'b0,
      declined : 1'b0,
      dbus_req : 1'b0,
      owner    : 1'b0
   };

   // ==========================================
   // state
   abt_ten_st_t                ten_ff;
   abt_ten_st_t                nxt_ten;

   logic [`ABT_ADDR_W-1:0]     sel_addr;
   logic                       sel_addr_only;
   logic                       gnt_qual;
   logic                       bus_free;
   logic                       retry_block;

   // ==========================================
   // burst address shaping
   abt_addr_sel u_addr_sel (
      .req_addr  (REQ_ADDR),
      .req_burst (REQ_BURST),
      .req_write (REQ_WRITE),
      .req_tt    (REQ_TT),
      .bus_addr  (sel_addr),
      .addr_only (sel_addr_only)
   );

   // ==========================================
   // snooping of other masters
   abt_snoop u_snoop (
      .clk       (CLK),
      .srst      (SRST),
      .ts_n_i    (TRANSFER_START_N_I),
      .own_ts_oe (ten_ff.ts_oe),
      .addr_i    (ADDR_I),
      .tt_i      (TRANSFER_TYPE_I),
      .snp_valid (SNP_VALID),
      .snp_addr  (SNP_ADDR),
      .snp_tt    (SNP_TT)
   );

   // ==========================================
   // grant qualification
   // busy low from anyone else keeps us off; we never drive it low in idle
   always_comb
   begin
      bus_free    = ADDR_BUS_BUSY_N_I;
      retry_block = ten_ff.addr_ack_n_d && !ADDR_RETRY_N;
      gnt_qual    = !BUS_GRANT_N && bus_free && !retry_block &&
                    !ten_ff.ts_pend;
   end

   // ==========================================
   // tenure sequencer
   always_comb
   begin
      nxt_ten          = ten_ff;
      nxt_ten.taken    = 1'b0;
      nxt_ten.done     = 1'b0;
      nxt_ten.declined = 1'b0;
      nxt_ten.dbus_req = 1'b0;
      nxt_ten.addr_ack_n_d   = !ADDR_ACK_N;

      // any start opens a window closed by the acknowledge; a new start wins
      if (!TRANSFER_START_N_I)
         nxt_ten.ts_pend = 1'b1;
      else if (!ADDR_ACK_N)
         nxt_ten.ts_pend = 1'b0;

      case (ten_ff.st)
         ABT_IDLE:
         begin
            if (REQ_VALID && gnt_qual)
            begin
               if (REQ_ABORT)
               begin
                  // busy stays released, mastership is declined
                  nxt_ten.declined = 1'b1;
               end
               else
               begin
                  nxt_ten.st       = ABT_OWN;
                  nxt_ten.owner    = 1'b1;
                  nxt_ten.abb_o    = 1'b0;
                  nxt_ten.abb_oe   = 1'b1;
                  nxt_ten.ts_o     = 1'b0;
                  nxt_ten.ts_oe    = 1'b1;
                  nxt_ten.a_o      = sel_addr;
                  nxt_ten.a_oe     = 1'b1;
                  nxt_ten.tt_o     = REQ_TT;
                  nxt_ten.tt_oe    = 1'b1;
                  nxt_ten.taken    = 1'b1;
                  nxt_ten.dbus_req = !sel_addr_only;
               end
            end
         end

         ABT_OWN:
         begin
            // address and type registers are not touched here
            nxt_ten.ts_o = 1'b1;
            if (!ADDR_ACK_N)
            begin
               nxt_ten.st       = ABT_NEG;
               nxt_ten.abb_o    = 1'b1;
               nxt_ten.ts_oe    = 1'b0;
               nxt_ten.a_oe     = 1'b0;
               nxt_ten.tt_oe    = 1'b0;
               nxt_ten.done     = 1'b1;
               nxt_ten.hold_cnt = NEG_LAST;
            end
         end

         ABT_NEG:
         begin
            // a whole cycle of driven high covers the half-cycle minimum
            if (ten_ff.hold_cnt == 2'd0)
            begin
               nxt_ten.st     = ABT_IDLE;
               nxt_ten.abb_oe = 1'b0;
               nxt_ten.owner  = 1'b0;
            end
            else
            begin
               nxt_ten.hold_cnt = ten_ff.hold_cnt - 2'd1;
            end
         end

         default:
         begin
            nxt_ten = TEN_RST;
         end
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         ten_ff <= TEN_RST;
      else
         ten_ff <= nxt_ten;
   end

   // ==========================================
   // outputs, all from ten_ff
   assign REQ_TAKEN           = ten_ff.taken;
   assign REQ_DONE            = ten_ff.done;
   assign REQ_DECLINED        = ten_ff.declined;
   assign DATA_BUS_REQ        = ten_ff.dbus_req;
   assign BUS_OWNER           = ten_ff.owner;
   assign ADDR_BUS_BUSY_N_O   = ten_ff.abb_o;
   assign ADDR_BUS_BUSY_N_OE  = ten_ff.abb_oe;
   assign TRANSFER_START_N_O  = ten_ff.ts_o;
   assign TRANSFER_START_N_OE = ten_ff.ts_oe;
   assign ADDR_O              = ten_ff.a_o;
   assign ADDR_OE             = ten_ff.a_oe;
   assign TRANSFER_TYPE_O     = ten_ff.tt_o;
   assign TRANSFER_TYPE_OE    = ten_ff.tt_oe;

endmodule

// >>> abt_tenure_assertions.sv
// checker for the address tenure ports: busy, start, address and snoop timing
// assumes a bind onto abt_tenure, with resolved pin levels on the _I ports
`timescale 1ns/1ns
module abt_tenure_chk
   import abt_pkg::*;
(
   input wire logic        CLK,
   input wire logic        SRST,
   input wire logic        REQ_VALID,
   input wire logic        REQ_ABORT,
   input wire logic        REQ_TAKEN,
   input wire logic        REQ_DONE,
   input wire logic        REQ_DECLINED,
   input wire logic        BUS_OWNER,
   input wire logic        SNP_VALID,
   input wire logic [31:0] SNP_ADDR,
   input wire logic [4:0]  SNP_TT,
   input wire logic        BUS_GRANT_N,
   input wire logic        ADDR_ACK_N,
   input wire logic        ADDR_RETRY_N,
   input wire logic        ADDR_BUS_BUSY_N_I,
   input wire logic        ADDR_BUS_BUSY_N_O,
   input wire logic        ADDR_BUS_BUSY_N_OE,
   input wire logic        TRANSFER_START_N_I,
   input wire logic        TRANSFER_START_N_O,
   input wire logic        TRANSFER_START_N_OE,
   input wire logic [31:0] ADDR_I,
   input wire logic [31:0] ADDR_O,
   input wire logic        ADDR_OE,
   input wire logic [4:0]  TRANSFER_TYPE_I
);
   default clocking dck @(posedge CLK);
   endclocking
   default disable iff (SRST);

   // ==========================================
   // taking and holding the bus
   chk_take_drives: assert property (
      REQ_TAKEN |-> !ADDR_BUS_BUSY_N_O && ADDR_BUS_BUSY_N_OE && !TRANSFER_START_N_O
         && TRANSFER_START_N_OE && ADDR_OE) else $error("take without pins driven");
   chk_take_cause: assert property (
      $rose(BUS_OWNER) |-> !$past(BUS_GRANT_N) && $past(ADDR_BUS_BUSY_N_I) && $past(REQ_VALID)
         && !$past(REQ_ABORT)) else $error("bus taken without a qualified grant");
   chk_start_pulse: assert property (
      REQ_TAKEN |=> TRANSFER_START_N_O || !TRANSFER_START_N_OE) else $error("start too long");
   chk_busy_hold: assert property (
      BUS_OWNER && !ADDR_BUS_BUSY_N_O && ADDR_ACK_N |=> !ADDR_BUS_BUSY_N_O && ADDR_BUS_BUSY_N_OE)
      else $error("busy dropped before acknowledge");
   chk_retry_block: assert property (
      !$past(ADDR_ACK_N) && !ADDR_RETRY_N |=> !REQ_TAKEN) else $error("take during retry");
   chk_grant_ignored: assert property (
      BUS_OWNER |=> !REQ_TAKEN) else $error("second take during tenure");
   chk_addr_steady: assert property (
      ADDR_OE && $past(ADDR_OE) |-> $stable(ADDR_O)) else $error("address moved in tenure");
   chk_decline_quiet: assert property (
      REQ_DECLINED |-> !BUS_OWNER && !ADDR_OE && !(ADDR_BUS_BUSY_N_OE && !ADDR_BUS_BUSY_N_O))
      else $error("declined grant still drove the bus");

   // ==========================================
   // release and snoop
   chk_ack_to_done: assert property (
      BUS_OWNER && !ADDR_BUS_BUSY_N_O && !ADDR_ACK_N |=> REQ_DONE) else $error("ack not seen");
   chk_release_seq: assert property (
      REQ_DONE |-> ADDR_BUS_BUSY_N_O && ADDR_BUS_BUSY_N_OE && !TRANSFER_START_N_OE && !ADDR_OE
         ##1 !ADDR_BUS_BUSY_N_OE && !BUS_OWNER) else $error("bad release order");
   chk_snoop_load: assert property (
      !TRANSFER_START_N_I && !TRANSFER_START_N_OE |=> SNP_VALID && SNP_ADDR == $past(ADDR_I)
         && SNP_TT == $past(TRANSFER_TYPE_I)) else $error("foreign start not captured");
endmodule

// >>> abt_far_model.sv
// far side model: arbiter grant level, address acknowledge, a second master
// assumes the bench resolves busy and start with pull-ups from the _oe pairs
`timescale 1ns/1ns
module abt_far_model
   import abt_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        gnt_on,
   input  wire logic [1:0]  ack_dly,
   input  wire logic        om_go,
   input  wire logic [31:0] om_addr,
   input  wire logic [4:0]  om_tt,
   input  wire logic        busy_w,
   input  wire logic        ts_w,
   input  wire logic        retry_on,
   output logic             addr_retry_n,
   output logic             bus_grant_n,
   output logic             addr_ack_n,
   output logic             om_busy_n_o,
   output logic             om_busy_n_oe,
   output logic             om_ts_n_o,
   output logic             om_ts_n_oe,
   output logic [31:0]      om_a_o,
   output logic [4:0]       om_tt_o
);
   logic [1:0] cnt_ff;
   logic       pend_ff;
   logic [1:0] om_st_ff;
   logic       om_take;

   // ==========================================
   // second master pins
   assign bus_grant_n  = !gnt_on;
   assign om_take      = (om_st_ff == 2'h0) && om_go && busy_w && bus_grant_n;
   assign om_busy_n_oe = (om_st_ff != 2'h0);
   assign om_busy_n_o  = (om_st_ff == 2'h3);
   assign om_ts_n_oe   = (om_st_ff == 2'h1) || (om_st_ff == 2'h2);
   assign om_ts_n_o    = (om_st_ff != 2'h1);

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         addr_ack_n <= 1'b1;
         addr_retry_n <= 1'b1;
         pend_ff    <= 1'b0;
         cnt_ff     <= 2'h0;
         om_st_ff   <= 2'h0;
         om_a_o     <= '0;
         om_tt_o    <= '0;
      end
      else
      begin
         // retry, when enabled, falls in the cycle after each acknowledge
         addr_retry_n <= !(retry_on && !addr_ack_n);
         // acknowledge any start after ack_dly extra cycles
         addr_ack_n <= 1'b1;
         if (!ts_w)
         begin
            cnt_ff     <= ack_dly;
            pend_ff    <= (ack_dly != 2'h0);
            addr_ack_n <= (ack_dly != 2'h0);
         end
         else if (pend_ff)
         begin
            cnt_ff     <= cnt_ff - 2'h1;
            pend_ff    <= (cnt_ff != 2'h1);
            addr_ack_n <= (cnt_ff != 2'h1);
         end
         // released lines keep changing so a stale value is never read as valid
         if (om_take)
            {om_a_o, om_tt_o} <= {om_addr, om_tt};
         else if (!om_ts_n_oe)
            {om_a_o, om_tt_o} <= ~{om_a_o, om_tt_o};
         case (om_st_ff)
            2'h0:    om_st_ff <= om_take ? 2'h1 : 2'h0;
            2'h1:    om_st_ff <= 2'h2;
            2'h2:    om_st_ff <= addr_ack_n ? 2'h2 : 2'h3;
            default: om_st_ff <= 2'h0;
         endcase
      end
   end
endmodule

// >>> abt_tenure_bench.sv
// self-checking bench of the address tenure block with the far side model
// assumes pull-ups on busy and start; retry follows each acknowledge only while retry_on is set
`timescale 1ns/1ns
`include "abt_cfg.svh"
module abt_tenure_bench
   import abt_pkg::*;
;
   logic        CLK, SRST, REQ_VALID, REQ_ABORT, REQ_BURST, REQ_WRITE, gnt_on, om_go;
   logic        REQ_TAKEN, REQ_DONE, REQ_DECLINED, DATA_BUS_REQ, BUS_OWNER, SNP_VALID;
   logic        ADDR_BUS_BUSY_N_O, ADDR_BUS_BUSY_N_OE, TRANSFER_START_N_O, TRANSFER_START_N_OE;
   logic        ADDR_OE, TRANSFER_TYPE_OE, BUS_GRANT_N, ADDR_ACK_N, busy_w, ts_w;
   logic        om_busy_n_o, om_busy_n_oe, om_ts_n_o, om_ts_n_oe, retry_on, ADDR_RETRY_N;
   logic [1:0]  ack_dly;
   logic [31:0] REQ_ADDR, SNP_ADDR, ADDR_O, addr_w, om_addr, om_a_o, oa;
   logic [4:0]  REQ_TT, SNP_TT, TRANSFER_TYPE_O, tt_w, om_tt, om_tt_o;
   logic [37:0] exp_q [$];
   logic [36:0] snp_q [$];
   logic [4:0]  tt_tab [8] = '{5'h00, 5'h02, 5'h04, 5'h14, 5'h1C, 5'h0A, 5'h0E, 5'h06};
   int          bad_count, n_checks, cyc, seed, i, k;

   // ==========================================
   // wires, design and far side
   assign busy_w = (ADDR_BUS_BUSY_N_OE ? ADDR_BUS_BUSY_N_O : 1'b1)
                 & (om_busy_n_oe ? om_busy_n_o : 1'b1);
   assign ts_w   = (TRANSFER_START_N_OE ? TRANSFER_START_N_O : 1'b1)
                 & (om_ts_n_oe ? om_ts_n_o : 1'b1);
   assign addr_w = ADDR_OE ? ADDR_O : om_a_o;
   assign tt_w   = TRANSFER_TYPE_OE ? TRANSFER_TYPE_O : om_tt_o;

   abt_tenure u_dut (.CLK, .SRST, .REQ_VALID, .REQ_ABORT, .REQ_ADDR, .REQ_TT, .REQ_BURST,
      .REQ_WRITE, .REQ_TAKEN, .REQ_DONE, .REQ_DECLINED, .DATA_BUS_REQ, .BUS_OWNER, .SNP_VALID,
      .SNP_ADDR, .SNP_TT, .BUS_GRANT_N, .ADDR_ACK_N, .ADDR_RETRY_N,
      .ADDR_BUS_BUSY_N_I(busy_w), .ADDR_BUS_BUSY_N_O, .ADDR_BUS_BUSY_N_OE,
      .TRANSFER_START_N_I(ts_w), .TRANSFER_START_N_O, .TRANSFER_START_N_OE,
      .ADDR_I(addr_w), .ADDR_O, .ADDR_OE, .TRANSFER_TYPE_I(tt_w), .TRANSFER_TYPE_O,
      .TRANSFER_TYPE_OE);

   abt_far_model u_far (.clk(CLK), .srst(SRST), .gnt_on, .ack_dly, .om_go, .om_addr, .om_tt,
      .busy_w, .ts_w, .retry_on, .addr_retry_n(ADDR_RETRY_N),
      .bus_grant_n(BUS_GRANT_N), .addr_ack_n(ADDR_ACK_N), .om_busy_n_o,
      .om_busy_n_oe, .om_ts_n_o, .om_ts_n_oe, .om_a_o, .om_tt_o);

   // ==========================================
   // tasks
   task automatic compare(input logic [37:0] e, input logic [37:0] g);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch at %0t expected %h got %h", $time, e, g);
      end
   endtask

   task automatic close_out();
      if (exp_q.size() != 0 || snp_q.size() != 0)
         bad_count++;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // mode[1] burst, mode[0] write; called at a falling edge
   task automatic tenure(input logic [31:0] a, input logic [4:0] tt, input logic [1:0] mode,
                         input logic ab, input logic [1:0] dly);
      logic [31:0] ea;
      ea = mode[1] ? a & (mode[0] ? `ABT_LINE_MASK : `ABT_DW_MASK) : a;
      if (!ab)
         exp_q.push_back({ea, tt, tt[1] || tt == 5'h14 || tt == 5'h1C});
      {REQ_ADDR, REQ_TT, REQ_BURST, REQ_WRITE} <= {a, tt, mode};
      REQ_ABORT <= ab;
      ack_dly   <= dly;
      REQ_VALID <= 1'b1;
      k = 0;
      do
      begin
         @(negedge CLK);
         k++;
      end
      while (REQ_TAKEN !== 1'b1 && REQ_DECLINED !== 1'b1 && k < 40);
      REQ_VALID <= 1'b0;
      if (ab)
      begin
         compare(38'h1, {37'h0, REQ_DECLINED});
         @(negedge CLK);
      end
      else
         while (REQ_DONE !== 1'b1 && k < 80)
         begin
            @(negedge CLK);
            k++;
         end
   endtask

   // ==========================================
   // result watcher and run control
   always @(negedge CLK)
   begin
      if (REQ_TAKEN === 1'b1)
         compare(exp_q.size() ? exp_q.pop_front() : 38'h0,
                 {ADDR_O, TRANSFER_TYPE_O, DATA_BUS_REQ});
      if (REQ_TAKEN === 1'b1)
         compare(38'h1, {37'h0, TRANSFER_TYPE_OE});
      if (REQ_DONE === 1'b1)
         compare(38'h0, {37'h0, TRANSFER_TYPE_OE});
      if (SNP_VALID === 1'b1)
         compare(snp_q.size() ? {snp_q.pop_front(), 1'b0} : 38'h1,
                 {SNP_ADDR, SNP_TT, 1'b0});
   end

   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         bad_count++;
         close_out();
      end
   end

   initial
   begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   initial
   begin
      SRST = 1'b1;
      {REQ_VALID, REQ_ABORT, REQ_ADDR, REQ_TT, REQ_BURST, REQ_WRITE} = '0;
      {gnt_on, ack_dly, om_go, om_addr, om_tt, retry_on} = '0;
      seed = $urandom(65);
      repeat (3) @(negedge CLK);
      SRST   <= 1'b0;
      gnt_on <= 1'b1;
      // back to back tenures, every burst mode and acknowledge delay
      for (i = 0; i < 8; i++)
         tenure($urandom, tt_tab[i], i[1:0], 1'b0, i[2:1]);
      tenure($urandom, 5'h02, 2'h2, 1'b1, 2'h0);
      // another master holds the bus while the grant is raised
      gnt_on  <= 1'b0;
      oa      = $urandom;
      om_addr <= oa;
      om_tt   <= 5'h0A;
      om_go   <= 1'b1;
      retry_on <= 1'b1;
      snp_q.push_back({oa, 5'h0A});
      k = 0;
      while (om_busy_n_oe !== 1'b1 && k < 20)
      begin
         @(negedge CLK);
         k++;
      end
      om_go  <= 1'b0;
      gnt_on <= 1'b1;
      tenure($urandom, 5'h0E, 2'h3, 1'b0, 2'h1);
      retry_on <= 1'b0;
      // reset in mid-run, then one more tenure
      SRST <= 1'b1;
      repeat (2) @(negedge CLK);
      SRST <= 1'b0;
      tenure($urandom, 5'h0A, 2'h0, 1'b0, 2'h2);
      close_out();
   end
endmodule

bind abt_tenure abt_tenure_chk u_chk (.CLK, .SRST, .REQ_VALID, .REQ_ABORT, .REQ_TAKEN,
   .REQ_DONE, .REQ_DECLINED, .BUS_OWNER, .SNP_VALID, .SNP_ADDR, .SNP_TT, .BUS_GRANT_N,
   .ADDR_ACK_N, .ADDR_RETRY_N, .ADDR_BUS_BUSY_N_I, .ADDR_BUS_BUSY_N_O, .ADDR_BUS_BUSY_N_OE,
   .TRANSFER_START_N_I, .TRANSFER_START_N_O, .TRANSFER_START_N_OE, .ADDR_I, .ADDR_O,
   .ADDR_OE, .TRANSFER_TYPE_I);
